// File: logic/cxv_consts.vh
`ifndef CXV_CONSTS_VH
`define CXV_CONSTS_VH

// ----------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------
`define CXV_RESET_VECTOR      32'hBFC00000
`define CXV_DEBUG_PROBE_VEC   32'hFF200200
`define CXV_DEBUG_NOPROBE_VEC 32'hBFC00480
`define CXV_BASE_CACHED       32'h80000000
`define CXV_BASE_BOOT         32'hBFC00200
`define CXV_BASE_CERR_UNCACHED 32'hA0000000

// ----------------------------------------------------------------
// Vector offsets
// ----------------------------------------------------------------
`define CXV_OFS_REFILL        32'h00000000
`define CXV_OFS_CACHE_ERR     32'h00000100
`define CXV_OFS_GENERAL       32'h00000180
`define CXV_OFS_INTERRUPT     32'h00000200

// ----------------------------------------------------------------
// Exception request bit positions, index 0 is rank 1 (highest)
// ----------------------------------------------------------------
`define CXV_NUM_EXC           20
`define CXV_EX_RESET          0
`define CXV_EX_DEBUG          1
`define CXV_EX_SOFT_RESET     2
`define CXV_EX_NMI            3
`define CXV_EX_IMP_BUS        4
`define CXV_EX_I_ADDR         5
`define CXV_EX_I_REFILL       6
`define CXV_EX_I_INVALID      7
`define CXV_EX_I_WATCH        8
`define CXV_EX_I_CACHE        9
`define CXV_EX_I_BUS          10
`define CXV_EX_INSN           11
`define CXV_EX_D_ADDR         12
`define CXV_EX_D_REFILL       13
`define CXV_EX_D_INVALID      14
`define CXV_EX_D_MOD          15
`define CXV_EX_D_CACHE        16
`define CXV_EX_D_WATCH        17
`define CXV_EX_D_BUS          18
`define CXV_EX_INTERRUPT      19

// ----------------------------------------------------------------
// Exception cause codes written for general exceptions
// ----------------------------------------------------------------
`define CXV_CODE_INT          5'h00
`define CXV_CODE_MOD          5'h01
`define CXV_CODE_TLBL         5'h02
`define CXV_CODE_TLBS         5'h03
`define CXV_CODE_ADEL         5'h04
`define CXV_CODE_ADES         5'h05
`define CXV_CODE_IBE          5'h06
`define CXV_CODE_DBE          5'h07
`define CXV_CODE_WATCH        5'h17

// ----------------------------------------------------------------
// Status field positions and reset values
// ----------------------------------------------------------------
`define CXV_UM_KERNEL         2'h0
`define CXV_CAUSE_PEND_W      8

`endif

// File: logic/cxv_prio_pick.v
`timescale 1ns/100ps
`include "cxv_consts.vh"

// Fixed-priority picker, lowest index wins
module cxv_prio_pick (
    input  wire [19:0] req_i,
    output reg  [19:0] grant_o,
    output wire        any_o
);
    integer k;
    reg     found;

    // ----------------------------------------------------------------
    // Priority scan
    // ----------------------------------------------------------------
    // First set bit from index 0 upward
    always @* begin
        found   = 1'b0;
        grant_o = 20'h00000;
        for (k = 0; k < `CXV_NUM_EXC; k = k + 1) begin
            if (req_i[k] && !found) begin
                grant_o[k] = 1'b1;
                found      = 1'b1;
            end
        end
    end

    assign any_o = |req_i;
endmodule

// File: logic/cxv_vector_calc.v
`timescale 1ns/100ps
`include "cxv_consts.vh"

// Vector composer: base plus offset, or fixed vectors
module cxv_vector_calc (
    input  wire [19:0] grant_i,
    input  wire        bootstrap_vector_select_i,
    input  wire        exception_level_i,
    input  wire        interrupt_vector_select_i,
    input  wire        debug_probe_present_i,
    output reg  [31:0] vector_o
);
    reg [31:0] base;
    reg [31:0] ofs;
    wire       is_cache;
    wire       is_refill;

    assign is_cache  = grant_i[`CXV_EX_I_CACHE] | grant_i[`CXV_EX_D_CACHE];
    assign is_refill = grant_i[`CXV_EX_I_REFILL] | grant_i[`CXV_EX_D_REFILL];

    // ----------------------------------------------------------------
    // Base and offset selection
    // ----------------------------------------------------------------
    always @* begin
        // Normal base from bootstrap select
        if (bootstrap_vector_select_i) begin
            base = `CXV_BASE_BOOT; // RULE12
        end else begin
            base = `CXV_BASE_CACHED; // RULE12
        end
        ofs = `CXV_OFS_GENERAL;
        if (is_cache) begin
            ofs = `CXV_OFS_CACHE_ERR; // RULE13
            if (bootstrap_vector_select_i) begin
                base = `CXV_BASE_BOOT; // RULE14
            end else begin
                base = `CXV_BASE_CERR_UNCACHED; // RULE13
            end
        end else if (is_refill) begin
            if (!exception_level_i) begin
                ofs = `CXV_OFS_REFILL; // RULE15
            end
        end else if (grant_i[`CXV_EX_INTERRUPT]) begin
            if (interrupt_vector_select_i) begin
                ofs = `CXV_OFS_INTERRUPT; // RULE16
            end
        end
        // Fixed vectors override base plus offset
        if (grant_i[`CXV_EX_RESET] | grant_i[`CXV_EX_SOFT_RESET] | grant_i[`CXV_EX_NMI]) begin
            vector_o = `CXV_RESET_VECTOR; // RULE10
        end else if (grant_i[`CXV_EX_DEBUG]) begin
            vector_o = debug_probe_present_i ? `CXV_DEBUG_PROBE_VEC
                                             : `CXV_DEBUG_NOPROBE_VEC; // RULE11
        end else begin
            vector_o = base + ofs; // RULE20
        end
    end
endmodule

// File: logic/cxv_exception_unit.v
// Overview of operation
// RULE1 - With exception level clear, privilege follows the user mode bits; the code also requires error level clear.
// RULE2 - Exception level or error level set forces kernel privilege.
// RULE3 - Taking an exception sets the exception level flag; the code sets it for general exceptions only.
// RULE4 - Return from exception clears the exception level flag; the code clears error level instead when that is set.
// RULE5 - General sequence for all but reset, soft reset, NMI, cache error; the code also excludes debug.
// RULE6 - Return PC captured only when exception level was clear.
// RULE7 - Report only the highest pending exception; others later.
// RULE8 - Ranks 1-10: reset, debug, soft reset, NMI, bus, fetch errors.
// RULE9 - Ranks 11-20: fetch bus, instruction, data errors, interrupt last.
// RULE10 - Reset, soft reset, NMI vector to the fixed boot address.
// RULE11 - Debug vector depends on the probe present bit.
// RULE12 - Other vectors are base plus offset; base chosen by bootstrap bit.
// RULE13 - Bootstrap clear: cache error base moves to uncached segment, offset 0x100.
// RULE14 - Bootstrap set: cache error base equals the boot base.
// RULE15 - Refill with exception level clear uses zero offset, else general.
// RULE16 - Interrupt uses dedicated offset only when vector select is set.
// RULE17 - General sequence writes delay slot, unit, code; keeps pending bits.
// RULE18 - Reset, soft reset, NMI save PC into the error return register.
// RULE19 - Soft reset or NMI sets the soft reset flag.
// RULE20 - Fetch redirects to base plus offset the cycle after commit.
`timescale 1ns/100ps
`include "cxv_consts.vh"

module cxv_exception_unit (
    input  wire        clk_i,
    input  wire        rst_i,
    // Pipeline side
    input  wire        commit_i,
    input  wire [19:0] exc_req_i,
    input  wire [31:0] fault_pc_i,
    input  wire        in_delay_slot_i,
    input  wire [1:0]  cop_unit_i,
    input  wire [4:0]  insn_cause_code_i,
    input  wire        data_is_store_i,
    input  wire        eret_i,
    input  wire        debug_return_i,
    // Software writes to mode state
    input  wire        sw_wr_i,
    input  wire        sw_exception_level_i,
    input  wire        sw_error_level_i,
    input  wire [1:0]  sw_user_mode_bits_i,
    input  wire        sw_bootstrap_vector_select_i,
    input  wire        sw_soft_reset_flag_i,
    input  wire        sw_epc_wr_i,
    input  wire [31:0] sw_epc_i,
    // Configuration and cause inputs
    input  wire        interrupt_vector_select_i,
    input  wire        debug_probe_present_i,
    input  wire [7:0]  pending_int_i,
    // Outputs
    output reg         redirect_o,
    output reg  [31:0] fetch_addr_o,
    output wire        kernel_mode_o,
    output wire [1:0]  user_mode_bits_o,
    output wire        exception_level_o,
    output wire        error_level_flag_o,
    output wire        bootstrap_vector_select_o,
    output wire        soft_reset_flag_o,
    output wire        debug_mode_o,
    output wire [31:0] exception_return_pc_o,
    output wire [31:0] error_return_pc_o,
    output wire        delay_slot_flag_o,
    output wire [1:0]  cop_unit_o,
    output wire [4:0]  exception_cause_code_o,
    output wire [7:0]  cause_pending_o
);

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    reg        exl_reg;
    reg        error_level_flag_reg;
    reg [1:0]  user_mode_bits_reg;
    reg        bootstrap_vector_select_reg;
    reg        soft_reset_flag_reg;
    reg        debug_mode_reg;
    reg [31:0] exception_return_pc_reg;
    reg [31:0] error_return_pc_reg;
    reg        delay_slot_flag_reg;
    reg [1:0]  cop_unit_reg;
    reg [4:0]  exception_cause_code_reg;

    wire [19:0] grant;
    wire        any_req;
    wire [31:0] vector;
    wire        take;
    wire        is_fixed;
    wire        is_soft_or_nmi;
    wire        is_cache_err;
    wire        is_general;
    reg  [4:0]  code_sel;

    // ----------------------------------------------------------------
    // Priority selection
    // ----------------------------------------------------------------
    // Picker reports only the top request
    cxv_prio_pick u_pick (
        .req_i   (exc_req_i),   // RULE8 RULE9
        .grant_o (grant),       // RULE7
        .any_o   (any_req)
    );

    // ----------------------------------------------------------------
    // Vector composition
    // ----------------------------------------------------------------
    cxv_vector_calc u_vec (
        .grant_i                   (grant),
        .bootstrap_vector_select_i (bootstrap_vector_select_reg),
        .exception_level_i         (exl_reg),
        .interrupt_vector_select_i (interrupt_vector_select_i),
        .debug_probe_present_i     (debug_probe_present_i),
        .vector_o                  (vector)
    );

    // Sequence classification
    assign take           = commit_i & any_req;
    assign is_soft_or_nmi = grant[`CXV_EX_SOFT_RESET] | grant[`CXV_EX_NMI];
    assign is_fixed       = grant[`CXV_EX_RESET] | is_soft_or_nmi;
    assign is_cache_err   = grant[`CXV_EX_I_CACHE] | grant[`CXV_EX_D_CACHE];
    assign is_general     = ~is_fixed & ~is_cache_err & ~grant[`CXV_EX_DEBUG]; // RULE5

    // ----------------------------------------------------------------
    // Cause code for general exceptions
    // ----------------------------------------------------------------
    always @* begin
        code_sel = insn_cause_code_i;
        if (grant[`CXV_EX_INTERRUPT]) begin
            code_sel = `CXV_CODE_INT;
        end else if (grant[`CXV_EX_I_ADDR]) begin
            code_sel = `CXV_CODE_ADEL;
        end else if (grant[`CXV_EX_D_ADDR]) begin
            code_sel = data_is_store_i ? `CXV_CODE_ADES : `CXV_CODE_ADEL;
        end else if (grant[`CXV_EX_I_REFILL] | grant[`CXV_EX_I_INVALID]) begin
            code_sel = `CXV_CODE_TLBL;
        end else if (grant[`CXV_EX_D_REFILL] | grant[`CXV_EX_D_INVALID]) begin
            code_sel = data_is_store_i ? `CXV_CODE_TLBS : `CXV_CODE_TLBL;
        end else if (grant[`CXV_EX_D_MOD]) begin
            code_sel = `CXV_CODE_MOD;
        end else if (grant[`CXV_EX_I_WATCH] | grant[`CXV_EX_D_WATCH]) begin
            code_sel = `CXV_CODE_WATCH;
        end else if (grant[`CXV_EX_I_BUS]) begin
            code_sel = `CXV_CODE_IBE;
        end else if (grant[`CXV_EX_D_BUS] | grant[`CXV_EX_IMP_BUS]) begin
            code_sel = `CXV_CODE_DBE;
        end
    end

    // ----------------------------------------------------------------
    // Mode flags
    // ----------------------------------------------------------------
    // Exception level: set on general take, cleared by return when error level is clear
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            exl_reg <= 1'b0;
        end else if (take && is_general) begin
            exl_reg <= 1'b1; // RULE3
        end else if (eret_i && !error_level_flag_reg) begin
            exl_reg <= 1'b0; // RULE4
        end else if (sw_wr_i) begin
            exl_reg <= sw_exception_level_i;
        end
    end

    // Error level, bootstrap select and soft reset flag
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            error_level_flag_reg        <= 1'b1;
            bootstrap_vector_select_reg <= 1'b1;
            soft_reset_flag_reg         <= 1'b0;
        end else if (take && is_fixed) begin
            error_level_flag_reg        <= 1'b1;
            bootstrap_vector_select_reg <= 1'b1;
            soft_reset_flag_reg         <= is_soft_or_nmi; // RULE19
        end else begin
            if (eret_i && error_level_flag_reg) begin
                error_level_flag_reg <= 1'b0;
            end else if (sw_wr_i) begin
                error_level_flag_reg <= sw_error_level_i;
            end
            if (sw_wr_i) begin
                bootstrap_vector_select_reg <= sw_bootstrap_vector_select_i;
                soft_reset_flag_reg         <= sw_soft_reset_flag_i;
            end
        end
    end

    // User mode bits and debug state
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            user_mode_bits_reg <= `CXV_UM_KERNEL;
            debug_mode_reg     <= 1'b0;
        end else begin
            if (sw_wr_i) begin
                user_mode_bits_reg <= sw_user_mode_bits_i;
            end
            if (take && grant[`CXV_EX_DEBUG]) begin
                debug_mode_reg <= 1'b1;
            end else if (debug_return_i) begin
                debug_mode_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Return addresses and cause
    // ----------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            exception_return_pc_reg  <= 32'h00000000;
            error_return_pc_reg      <= 32'h00000000;
            delay_slot_flag_reg      <= 1'b0;
            cop_unit_reg             <= 2'h0;
            exception_cause_code_reg <= 5'h00;
        end else begin
            if (take && is_general) begin
                if (!exl_reg) begin
                    exception_return_pc_reg <= fault_pc_i; // RULE6
                end
                delay_slot_flag_reg      <= in_delay_slot_i; // RULE17
                cop_unit_reg             <= cop_unit_i;      // RULE17
                exception_cause_code_reg <= code_sel;        // RULE17
            end else if (sw_epc_wr_i) begin
                exception_return_pc_reg <= sw_epc_i;
            end
            if (take && (is_fixed || is_cache_err)) begin
                error_return_pc_reg <= fault_pc_i; // RULE18
            end
        end
    end

    // ----------------------------------------------------------------
    // Fetch redirect
    // ----------------------------------------------------------------
    // Registered so fetch moves the cycle after commit
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            redirect_o   <= 1'b0;
            fetch_addr_o <= 32'h00000000;
        end else begin
            redirect_o <= take; // RULE20
            if (take) begin
                fetch_addr_o <= vector; // RULE20
            end
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    // Kernel whenever either level flag set, else from mode bits
    assign kernel_mode_o = exl_reg | error_level_flag_reg |
                           (user_mode_bits_reg == `CXV_UM_KERNEL); // RULE1 RULE2
    assign user_mode_bits_o          = user_mode_bits_reg;
    assign exception_level_o         = exl_reg;
    assign error_level_flag_o        = error_level_flag_reg;
    assign bootstrap_vector_select_o = bootstrap_vector_select_reg;
    assign soft_reset_flag_o         = soft_reset_flag_reg;
    assign debug_mode_o              = debug_mode_reg;
    assign exception_return_pc_o     = exception_return_pc_reg;
    assign error_return_pc_o         = error_return_pc_reg;
    assign delay_slot_flag_o         = delay_slot_flag_reg;
    assign cop_unit_o                = cop_unit_reg;
    assign exception_cause_code_o    = exception_cause_code_reg;
    // Pending bits pass through untouched
    assign cause_pending_o           = pending_int_i; // RULE17

endmodule

// File: verif/cxv_exception_unit_props.sv
`timescale 1ns/100ps
`include "cxv_consts.vh"

// Port-level checker for the exception unit
module cxv_exception_unit_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        commit_i,
    input wire logic [19:0] exc_req_i,
    input wire logic [31:0] fault_pc_i,
    input wire logic        eret_i,
    input wire logic        sw_epc_wr_i,
    input wire logic        debug_probe_present_i,
    input wire logic        redirect_o,
    input wire logic [31:0] fetch_addr_o,
    input wire logic        kernel_mode_o,
    input wire logic [1:0]  user_mode_bits_o,
    input wire logic        exception_level_o,
    input wire logic        error_level_flag_o,
    input wire logic        soft_reset_flag_o,
    input wire logic [31:0] exception_return_pc_o,
    input wire logic [31:0] error_return_pc_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // Take sequences
    // ------------------------------------------------------------
    sequence take_s;
        commit_i && (exc_req_i != 20'h00000);
    endsequence
    sequence gen_take_s;
        commit_i && (exc_req_i[3:0] == 4'h0) && (exc_req_i[8:4] != 5'h00);
    endsequence
    sequence soft_take_s;
        commit_i && (exc_req_i[3:0] == 4'h4);
    endsequence

    redirect_pulse_a: assert property (take_s |=> redirect_o)
        else $error("redirect missing after take");
    quiet_redirect_a: assert property (!(commit_i && (exc_req_i != 20'h00000)) |=> !redirect_o)
        else $error("redirect without take");
    user_priv_a: assert property (!exception_level_o && !error_level_flag_o |->
        kernel_mode_o == (user_mode_bits_o == 2'h0)) else $error("privilege not from mode bits");
    erl_kernel_a: assert property (error_level_flag_o || exception_level_o |-> kernel_mode_o)
        else $error("kernel not forced");
    exl_set_a: assert property (gen_take_s |=> exception_level_o)
        else $error("exception level not set");
    epc_capture_a: assert property (gen_take_s ##0 !exception_level_o |=>
        exception_return_pc_o == $past(fault_pc_i)) else $error("return pc not captured");
    epc_hold_a: assert property (gen_take_s ##0 (exception_level_o && !sw_epc_wr_i) |=>
        $stable(exception_return_pc_o)) else $error("return pc overwritten");
    eret_clear_a: assert property (eret_i && !commit_i && exception_level_o &&
        !error_level_flag_o |=> !exception_level_o) else $error("return did not clear level");
    reset_vec_a: assert property (commit_i && exc_req_i[0] |=>
        fetch_addr_o == `CXV_RESET_VECTOR) else $error("reset vector wrong");
    soft_save_a: assert property (soft_take_s |=> (error_return_pc_o == $past(fault_pc_i)) &&
        soft_reset_flag_o && error_level_flag_o) else $error("soft reset state wrong");
    debug_vec_a: assert property (commit_i && (exc_req_i[1:0] == 2'h2) |=>
        fetch_addr_o == ($past(debug_probe_present_i) ? 32'hFF200200 : 32'hBFC00480))
        else $error("debug vector wrong");
endmodule

// File: verif/cxv_pipe_model.sv
`timescale 1ns/100ps

// Pipeline stand-in: holds posted exceptions and commits them
module cxv_pipe_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        post_i,
    input  wire logic [19:0] post_req_i,
    input  wire logic        stall_i,
    output logic             commit_o,
    output logic      [19:0] exc_req_o
);
    logic [19:0] pend_reg;

    // Commit while anything is pending and not stalled
    assign commit_o  = (pend_reg != 20'h00000) && !stall_i;
    assign exc_req_o = pend_reg;

    // Retire only the winner; lower ones are offered again
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_reg <= 20'h00000;
        end else if (post_i) begin
            pend_reg <= pend_reg | post_req_i;
        end else if (commit_o) begin
            pend_reg <= pend_reg & (pend_reg - 20'h00001);
        end
    end
endmodule

// File: verif/cxv_exception_unit_tb.sv
`timescale 1ns/100ps
`include "cxv_consts.vh"

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module cxv_exception_unit_tb;
    logic        clk_i, rst_i, commit_i, eret_i, debug_return_i, sw_wr_i, sw_epc_wr_i;
    logic        sw_exception_level_i, sw_error_level_i, sw_bootstrap_vector_select_i;
    logic        interrupt_vector_select_i, debug_probe_present_i, post_i, stall_i, data_is_store_i;
    logic        redirect_o, kernel_mode_o, exception_level_o, error_level_flag_o;
    logic        bootstrap_vector_select_o, soft_reset_flag_o, debug_mode_o, delay_slot_flag_o;
    logic [1:0]  user_mode_bits_o, cop_unit_o, sw_user_mode_bits_i;
    logic [4:0]  exception_cause_code_o;
    logic [7:0]  cause_pending_o, pending_int_i;
    logic [19:0] exc_req_i, post_req_i;
    logic [31:0] fault_pc_i, fetch_addr_o, exception_return_pc_o, error_return_pc_o;
    int          mismatches, cmp_count;
    int          gen_bits[10] = '{4, 5, 7, 8, 10, 12, 14, 15, 17, 18};

    cxv_exception_unit cxv_exception_unit_i (.*, .in_delay_slot_i(1'b1), .cop_unit_i(2'h3),
        .insn_cause_code_i(5'h0A), .sw_soft_reset_flag_i(1'b0), .sw_epc_i(32'h00001000));

    cxv_pipe_model cxv_pipe_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .post_i(post_i), .post_req_i(post_req_i),
        .stall_i(stall_i), .commit_o(commit_i), .exc_req_o(exc_req_i)
    );

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic set_mode(input logic exl, input logic error_level_flag, input logic bootstrap_vector_select);
        @(posedge clk_i);
        sw_wr_i                      <= 1'b1;
        sw_epc_wr_i                  <= 1'b1;
        sw_exception_level_i         <= exl;
        sw_error_level_i             <= error_level_flag;
        sw_bootstrap_vector_select_i <= bootstrap_vector_select;
        @(posedge clk_i);
        sw_wr_i     <= 1'b0;
        sw_epc_wr_i <= 1'b0;
        @(negedge clk_i);
        `CHK("kernel_mode", exl | error_level_flag, kernel_mode_o)
    endtask

    task automatic post(input logic [19:0] req, input logic [31:0] pc);
        @(posedge clk_i);
        post_i     <= 1'b1;
        post_req_i <= req;
        fault_pc_i <= pc;
        @(posedge clk_i);
        post_i <= 1'b0;
    endtask

    task automatic wait_redir(input logic [31:0] exp);
        int n;
        n = 0;
        while (redirect_o !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        `CHK("redirect", 1'b1, redirect_o)
        `CHK("fetch_addr", exp, fetch_addr_o)
        @(negedge clk_i);
    endtask

    task automatic run_vec(input int b, input logic bootstrap_vector_select, exl, iv, prb, input logic [31:0] exp);
        logic [31:0] pc;
        pc = 32'h00400100 + b * 4;
        @(posedge clk_i);
        interrupt_vector_select_i <= iv;
        debug_probe_present_i     <= prb;
        set_mode(exl, 1'b0, bootstrap_vector_select);
        post(20'h00001 << b, pc);
        wait_redir(exp);
        if (b == 0 || b == 2 || b == 3) begin
            `CHK("error_pc", pc, error_return_pc_o)
            `CHK("soft_flag", b != 0, soft_reset_flag_o)
            `CHK("bev", 1'b1, bootstrap_vector_select_o)
        end else if (b == 9 || b == 16) begin
            `CHK("error_pc", pc, error_return_pc_o)
        end else if (b == 1) begin
            `CHK("debug", 1'b1, debug_mode_o)
            @(posedge clk_i);
            debug_return_i <= 1'b1;
            @(posedge clk_i);
            debug_return_i <= 1'b0;
        end else begin
            `CHK("exl", 1'b1, exception_level_o)
            `CHK("epc", exl ? 32'h00001000 : pc, exception_return_pc_o)
            `CHK("slot_unit", 3'h7, {delay_slot_flag_o, cop_unit_o})
            if (b == 19 || b == 11) begin
                `CHK("code", b == 19 ? `CXV_CODE_INT : 5'h0A, exception_cause_code_o)
            end
        end
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {rst_i, eret_i, debug_return_i, sw_wr_i, sw_epc_wr_i, post_i, stall_i} = 7'h40;
        {sw_exception_level_i, sw_error_level_i, sw_bootstrap_vector_select_i} = 3'h0;
        {interrupt_vector_select_i, debug_probe_present_i, data_is_store_i} = 3'h0;
        sw_user_mode_bits_i = 2'h2;
        pending_int_i = 8'hA5;
        post_req_i = 20'h00000;
        fault_pc_i = 32'h00000000;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK("reset_state", 3'h7, {error_level_flag_o, bootstrap_vector_select_o, kernel_mode_o})
        run_vec(2, 0, 0, 0, 0, `CXV_RESET_VECTOR);
        run_vec(3, 0, 0, 0, 0, `CXV_RESET_VECTOR);
        run_vec(0, 0, 1, 1, 1, `CXV_RESET_VECTOR);
        run_vec(1, 0, 0, 0, 1, 32'hFF200200);
        run_vec(1, 1, 0, 0, 0, 32'hBFC00480);
        run_vec(6, 1, 0, 0, 0, 32'hBFC00200);
        run_vec(13, 1, 1, 0, 0, 32'hBFC00380);
        run_vec(6, 0, 0, 0, 0, 32'h80000000);
        run_vec(13, 0, 1, 0, 0, 32'h80000180);
        run_vec(9, 1, 0, 0, 0, 32'hBFC00300);
        run_vec(16, 0, 0, 0, 0, 32'hA0000100);
        run_vec(19, 1, 0, 1, 0, 32'hBFC00400);
        run_vec(19, 1, 0, 0, 0, 32'hBFC00380);
        run_vec(19, 0, 0, 1, 0, 32'h80000200);
        run_vec(19, 0, 1, 0, 0, 32'h80000180);
        run_vec(11, 1, 0, 0, 0, 32'hBFC00380);
        run_vec(7, 1, 1, 0, 0, 32'hBFC00380);
        foreach (gen_bits[i]) run_vec(gen_bits[i], 0, 0, 0, 0, 32'h80000180);
        // Return from exception, then error level alone
        set_mode(1'b1, 1'b0, 1'b0);
        @(posedge clk_i);
        eret_i <= 1'b1;
        @(posedge clk_i);
        eret_i <= 1'b0;
        @(negedge clk_i);
        `CHK("eret_exl", 1'b0, exception_level_o)
        set_mode(1'b0, 1'b1, 1'b0);
        // Three pending at once, stalled first, then back to back
        set_mode(1'b0, 1'b0, 1'b0);
        @(posedge clk_i);
        stall_i                   <= 1'b1;
        interrupt_vector_select_i <= 1'b1;
        post(20'hC1000, 32'h00400800);
        repeat (3) @(negedge clk_i);
        `CHK("stalled", 1'b0, redirect_o)
        @(posedge clk_i);
        stall_i <= 1'b0;
        wait_redir(32'h80000180);
        wait_redir(32'h80000180);
        wait_redir(32'h80000200);
        `CHK("multi_epc", 32'h00400800, exception_return_pc_o)
        // Debug outranks nonmaskable interrupt
        set_mode(1'b0, 1'b0, 1'b1);
        post(20'h0000A, 32'h00400900);
        wait_redir(32'hBFC00480);
        wait_redir(`CXV_RESET_VECTOR);
        `CHK("pending", 8'hA5, cause_pending_o)
        pending_int_i <= 8'h3C;
        @(negedge clk_i);
        `CHK("pending2", 8'h3C, cause_pending_o)
        end_sim();
    end
endmodule

bind cxv_exception_unit cxv_exception_unit_props cxv_exception_unit_props_i (.*);
